/* core/sfc_packet_commit.sv */
// Purpose: packet commit logic of an in endpoint slave fifo
// Assumes: strobes arrive as pins, config inputs come from same-clock logic
// Notes: commits leave through a two-entry buffer, o_stall_r holds off the master
`timescale 1ns/1ps

module sfc_packet_commit #(
    parameter int BYTES_PER_WORD = sfc_pkg::BYTES_PER_WORD_DEF
) (
    // clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_ce,
    // master side pins, asynchronous to i_clk_sys
    input wire logic i_slave_write_strobe,
    input wire logic i_packet_end_strobe,
    // configuration from device logic
    input wire logic i_auto_mode,
    input wire logic [sfc_pkg::COUNT_W-1:0] i_auto_commit_length,
    // commit stream toward the usb engine
    output logic o_commit_valid_r,
    output sfc_pkg::sfc_commit_type o_commit_r,
    input wire logic i_commit_ready,
    // status back to the master
    output logic o_stall_r,
    output logic o_pkt_end_lost_r,
    output logic [sfc_pkg::COUNT_W-1:0] o_fill_bytes_r
);

    // an eight-bit master bus sets BYTES_PER_WORD to one
    // step added per accepted write, cast to counter width
    localparam logic [sfc_pkg::COUNT_W-1:0] WORD_STEP = sfc_pkg::COUNT_W'(BYTES_PER_WORD);

    // two flop synchronisers for the pins
    logic wr_meta_r;
    logic wr_sync_r;
    logic pe_meta_r;
    logic pe_sync_r;

    // cleared in reset so that no false strobe follows the release
    // pins pass two flops before any logic reads them
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            wr_meta_r <= 1'b0;
            wr_sync_r <= 1'b0;
            pe_meta_r <= 1'b0;
            pe_sync_r <= 1'b0;
        end else if (i_ce) begin
            wr_meta_r <= i_slave_write_strobe;
            wr_sync_r <= wr_meta_r;
            pe_meta_r <= i_packet_end_strobe;
            pe_sync_r <= pe_meta_r;
        end
    end

    // fill counter and commit buffer state
    logic [sfc_pkg::COUNT_W-1:0] fill_r;
    logic [sfc_pkg::BUF_CNT_W-1:0] buf_cnt_r;
    sfc_pkg::sfc_commit_type tail_r;

    // full test of a buffer count, shared by the strobe gate and the stall flag
    function automatic logic buf_is_full(input logic [sfc_pkg::BUF_CNT_W-1:0] cnt);
        buf_is_full = (cnt == sfc_pkg::BUF_FULL);
    endfunction

    // strobes are taken only while the buffer has room for a commit
    // a strobe refused here is gone for good: the master must watch o_stall_r
    wire take = !buf_is_full(buf_cnt_r);
    // a write and an end strobe in one cycle both count, except on the auto trigger write where the end strobe is lost
    wire wr_take = wr_sync_r && take;
    wire pe_take = pe_sync_r && take;

    // fill including a write in this cycle
    wire [sfc_pkg::COUNT_W-1:0] fill_after = wr_take ? fill_r + WORD_STEP : fill_r;

    // length match fires only on the write that reaches the level
    wire auto_hit = i_auto_mode && wr_take && (fill_after >= i_auto_commit_length);

    // end strobe on the trigger write is swallowed, as the device does
    wire pe_lost = auto_hit && pe_take;
    wire manual_hit = pe_take && !auto_hit;

    // at most one push per cycle: auto and manual never fire together
    // the descriptor length includes a write landing in the same cycle
    // so a packet closed with its last word carries that word
    wire push_en = auto_hit || manual_hit;
    wire sfc_pkg::sfc_commit_type push_data = '{auto_commit: auto_hit, length: fill_after};

    // counter clears on any commit, else follows the writes
    wire [sfc_pkg::COUNT_W-1:0] fill_nxt = push_en ? sfc_pkg::FILL_RST : fill_after;

    // buffer bookkeeping: pop frees the head, push fills the first free slot
    wire pop_en = o_commit_valid_r && i_commit_ready;
    wire [sfc_pkg::BUF_CNT_W-1:0] buf_cnt_nxt =
        buf_cnt_r + (push_en ? sfc_pkg::BUF_ONE : sfc_pkg::BUF_EMPTY)
                  - (pop_en ? sfc_pkg::BUF_ONE : sfc_pkg::BUF_EMPTY);
    // entries left after a pop, before the push is counted
    wire [sfc_pkg::BUF_CNT_W-1:0] kept = pop_en ? buf_cnt_r - sfc_pkg::BUF_ONE : buf_cnt_r;
    // head loads the push when empty after pop, else the moved tail
    wire head_load_push = push_en && (kept == sfc_pkg::BUF_EMPTY);
    wire head_load_tail = pop_en && (buf_cnt_r == sfc_pkg::BUF_FULL);
    wire tail_load = push_en && (kept == sfc_pkg::BUF_ONE);

    // flags are registered so that every output leaves a flop
    // fill counter and status flags
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            fill_r <= sfc_pkg::FILL_RST;
            o_fill_bytes_r <= sfc_pkg::FILL_RST;
            o_pkt_end_lost_r <= 1'b0;
            o_stall_r <= 1'b0;
        end else if (i_ce) begin
            fill_r <= fill_nxt;
            o_fill_bytes_r <= fill_nxt;
            o_pkt_end_lost_r <= pe_lost;
            o_stall_r <= buf_is_full(buf_cnt_nxt); // registered inverse of take
        end
    end

    // the tail only ever feeds the head, so commits leave in order
    // two-entry commit buffer, head is the output register
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            buf_cnt_r <= sfc_pkg::BUF_EMPTY;
            o_commit_valid_r <= 1'b0;
            o_commit_r <= sfc_pkg::COMMIT_RST;
            tail_r <= sfc_pkg::COMMIT_RST;
        end else if (i_ce) begin
            buf_cnt_r <= buf_cnt_nxt;
            o_commit_valid_r <= (buf_cnt_nxt != sfc_pkg::BUF_EMPTY);
            if (head_load_tail) begin
                o_commit_r <= tail_r;
            end else if (head_load_push) begin
                o_commit_r <= push_data;
            end
            if (tail_load) begin
                tail_r <= push_data;
            end
        end
    end

    // checks sit next to the logic above and watch internal nets too
    // most of them look only at edges where the enable runs
    // reset disables them all, the first edge after release is safe
    // checks, most only while the enable runs, a_ce_freeze while it is low, four at every edge
    a_manual_commit: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && manual_hit) |=> (o_commit_valid_r && fill_r == sfc_pkg::FILL_RST))
        else $error("end strobe did not commit the held data");

    a_end_with_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && manual_hit && wr_take) |-> (push_data.length == fill_r + WORD_STEP))
        else $error("write in the end strobe cycle missing from packet");

    a_auto_commit: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && i_auto_mode && wr_take && fill_r + WORD_STEP >= i_auto_commit_length)
        |-> (push_en && push_data.auto_commit) ##1 (fill_r == sfc_pkg::FILL_RST))
        else $error("fill reached auto length without commit");

    a_end_lost: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && auto_hit && pe_take) |=> (o_pkt_end_lost_r && buf_cnt_r != sfc_pkg::BUF_EMPTY
        && fill_r == sfc_pkg::FILL_RST))
        else $error("end strobe on trigger write was not dropped");

    a_write_once: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && wr_take && !push_en) |=> (fill_r == $past(fill_r) + WORD_STEP))
        else $error("write did not add exactly one word");

    a_buf_bound: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (buf_cnt_r == sfc_pkg::BUF_FULL) |-> (o_stall_r && !push_en))
        else $error("commit pushed into a full buffer");

    // descriptor stands unchanged until the usb side takes it
    a_commit_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (o_commit_valid_r && !i_commit_ready) |=> (o_commit_valid_r && $stable(o_commit_r)))
        else $error("descriptor changed before it was taken");

    // valid mirrors a non-empty buffer at every edge
    a_valid_count: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_commit_valid_r == (buf_cnt_r != sfc_pkg::BUF_EMPTY))
        else $error("valid flag disagrees with buffer count");

    // a full buffer refuses both strobes, so the fill stays put
    a_stall_refuse: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && o_stall_r) |=> (fill_r == $past(fill_r) && !o_pkt_end_lost_r))
        else $error("strobe taken while the buffer was full");

    // enable low freezes every flop, the synchronisers included
    a_ce_freeze: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !i_ce |=> ($stable(fill_r) && $stable(buf_cnt_r) && $stable(o_commit_r)
        && $stable(wr_sync_r) && $stable(pe_sync_r) && $stable(o_pkt_end_lost_r)))
        else $error("state moved while the enable was low");

    // pins take exactly two flops on their way in, once per edge
    a_sync_stage: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_ce |=> (wr_sync_r == $past(wr_meta_r) && pe_sync_r == $past(pe_meta_r)))
        else $error("synchroniser skipped or repeated a stage");

    // a descriptor marked automatic only ever comes from auto mode
    a_auto_flag_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && push_en && !i_auto_mode && buf_cnt_r == sfc_pkg::BUF_EMPTY)
        |=> (o_commit_valid_r && !o_commit_r.auto_commit))
        else $error("manual commit marked as automatic");

    // the lost pulse comes only from a strobe that met the trigger write
    a_lost_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && !(auto_hit && pe_take)) |=> !o_pkt_end_lost_r)
        else $error("lost pulse without a clash");

    // a packet closed with a write carries that word, seen at the output
    a_end_word_out: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && manual_hit && wr_take && buf_cnt_r == sfc_pkg::BUF_EMPTY)
        |=> (o_commit_r.length == $past(o_fill_bytes_r) + WORD_STEP))
        else $error("word written with the end strobe left out");

    // a pop from a full buffer moves the newer tail entry up
    a_commit_order: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_ce && pop_en && buf_cnt_r == sfc_pkg::BUF_FULL)
        |=> (o_commit_valid_r && o_commit_r == $past(tail_r)))
        else $error("buffered commit lost or reordered");

    // status copy of the fill counter never drifts from it
    a_fill_mirror: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        o_fill_bytes_r == fill_r)
        else $error("fill status differs from the counter");

endmodule

/* core/sfc_pkg.sv */
// Purpose: shared constants and types of the slave fifo packet commit block
// Assumes: one interface clock domain, commits leave as length descriptors
// Notes: the rule overview below is the reference for the tags in the code
//
// Overview of operation
// - packet end strobe commits held data, even one
// - end strobe may coincide with last write
// - auto mode commits when fill reaches length
// - end strobe on auto trigger write is lost
package sfc_pkg;

    // width of the byte fill counter, covers the whole fifo space in bytes
    localparam int COUNT_W = 13;
    // default bytes carried by one written word
    localparam int BYTES_PER_WORD_DEF = 2;
    // entries in the commit buffer toward the usb engine
    localparam int BUF_DEPTH = 2;
    localparam int BUF_CNT_W = 2;

    // reset and step values
    localparam logic [COUNT_W-1:0] FILL_RST = 13'h0000;
    localparam logic [BUF_CNT_W-1:0] BUF_EMPTY = 2'h0;
    localparam logic [BUF_CNT_W-1:0] BUF_FULL = 2'h2;
    localparam logic [BUF_CNT_W-1:0] BUF_ONE = 2'h1;

    // one committed packet as handed to the usb side
    typedef struct packed {
        logic auto_commit;              // set when committed by length match
        logic [COUNT_W-1:0] length;     // bytes in the packet
    } sfc_commit_type;

    localparam sfc_commit_type COMMIT_RST = '{auto_commit: 1'b0, length: FILL_RST};

endpackage

/* test/sfc_usb_sink.sv */
// Purpose: usb engine side model that takes commit descriptors
// Assumes: descriptors offered as valid and ready on the system clock
// Notes: holding ready low lets the bench fill the two entry buffer
`timescale 1ns/1ps
module sfc_usb_sink (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // descriptor stream
    input wire logic i_commit_valid,
    input wire sfc_pkg::sfc_commit_type i_commit,
    output logic o_commit_ready,
    // bench control and results
    input wire logic i_hold,
    output logic [7:0] o_taken_r,
    output sfc_pkg::sfc_commit_type o_last_r
);
    // ready withdrawn while the bench asks for a stall
    assign o_commit_ready = !i_hold;
    // count and keep each descriptor taken, only the newest is kept
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_taken_r <= 8'h00;
            o_last_r <= sfc_pkg::COMMIT_RST;
        end else if (i_commit_valid && o_commit_ready) begin
            o_taken_r <= o_taken_r + 8'h01;
            o_last_r <= i_commit;
        end
    end
endmodule

/* test/tb.sv */
// Purpose: self-checking bench for the packet commit block
// Assumes: strobe effects show three edges after the pin edge
// Notes: auto length of four bytes, two bytes per written word
`timescale 1ns/1ps
module tb;
    // clock, pins and partner control
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, pe = 1'b0, am = 1'b0, hold = 1'b1, ce = 1'b1;
    logic [12:0] len = 13'h0004;
    logic cv, rdy, stall, lost, lost_seen = 1'b0;
    logic [12:0] fill;
    logic [7:0] taken;
    sfc_pkg::sfc_commit_type cd, last;
    int miscompares = 0, tests_run = 0;
    sfc_packet_commit i_sfc_packet_commit (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce),
        .i_slave_write_strobe(wr), .i_packet_end_strobe(pe), .i_auto_mode(am),
        .i_auto_commit_length(len), .o_commit_valid_r(cv), .o_commit_r(cd),
        .i_commit_ready(rdy), .o_stall_r(stall), .o_pkt_end_lost_r(lost),
        .o_fill_bytes_r(fill));
    sfc_usb_sink i_sfc_usb_sink (.i_clk_sys(clk), .i_rstn(rstn), .i_commit_valid(cv),
        .i_commit(cd), .o_commit_ready(rdy), .i_hold(hold), .o_taken_r(taken),
        .o_last_r(last));
    // 200 MHz clock
    initial forever #2.5 clk = ~clk;
    // the lost pulse lasts one cycle, so latch it
    always @(posedge clk) if (lost === 1'b1) lost_seen <= 1'b1;
    task chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // wait n edges, then let their updates land
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // n back to back writes, end strobe optionally with the last one
    task pulse(input int n, input logic p);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            wr <= 1'b1;
            pe <= p && (i == n - 1);
        end
        @(posedge clk);
        wr <= 1'b0;
        pe <= 1'b0;
    endtask
    task t_manual;
        pulse(1, 1'b0);
        cyc(5);
        chk({3'h0, fill}, 16'h0002);
        pulse(1, 1'b1);
        cyc(5);
        chk({2'h0, last}, 16'h0004);
        pulse(1, 1'b1);
        cyc(5);
        chk({2'h0, last}, 16'h0002);
        chk({8'h0, taken}, 16'h0002);
        $display("test manual done");
    endtask
    task t_auto;
        @(posedge clk);
        am <= 1'b1;
        hold <= 1'b1;
        pulse(2, 1'b0);
        pulse(1, 1'b1);
        cyc(6);
        chk({15'h0, stall}, 16'h0001);
        @(posedge clk);
        hold <= 1'b0;
        cyc(1);
        chk({2'h0, last}, 16'h2004);
        cyc(2);
        chk({8'h0, taken}, 16'h0004);
        chk({2'h0, last}, 16'h0002);
        chk({15'h0, stall}, 16'h0000);
        chk({15'h0, lost_seen}, 16'h0000);
        $display("test auto done");
    endtask
    task t_lost;
        pulse(2, 1'b1);
        cyc(6);
        chk({15'h0, lost_seen}, 16'h0001);
        chk({8'h0, taken}, 16'h0005);
        chk({2'h0, last}, 16'h2004);
        $display("test lost done");
    endtask
    // end strobe alone for one cycle, no write with it
    task end_only;
        @(posedge clk);
        pe <= 1'b1;
        @(posedge clk);
        pe <= 1'b0;
    endtask
    task t_held;
        @(posedge clk);
        am <= 1'b0;
        hold <= 1'b1;
        pulse(1, 1'b0);
        cyc(4);
        chk({3'h0, fill}, 16'h0002);
        chk({15'h0, cv}, 16'h0000);
        end_only;
        cyc(4);
        chk({15'h0, cv}, 16'h0001);
        chk({3'h0, fill}, 16'h0000);
        @(posedge clk);
        hold <= 1'b0;
        cyc(2);
        chk({2'h0, last}, 16'h0002);
        chk({8'h0, taken}, 16'h0006);
        chk({15'h0, cv}, 16'h0000);
        $display("test held done");
    endtask
    task t_freeze;
        pulse(1, 1'b0);
        cyc(4);
        @(posedge clk);
        ce <= 1'b0;
        pulse(1, 1'b1);
        cyc(4);
        chk({3'h0, fill}, 16'h0002);
        chk({8'h0, taken}, 16'h0006);
        @(posedge clk);
        ce <= 1'b1;
        cyc(3);
        end_only;
        cyc(4);
        chk({8'h0, taken}, 16'h0007);
        chk({2'h0, last}, 16'h0002);
        $display("test freeze done");
    endtask
    task t_stall;
        @(posedge clk);
        hold <= 1'b1;
        pulse(1, 1'b1);
        pulse(1, 1'b1);
        pulse(1, 1'b0);
        cyc(4);
        chk({15'h0, stall}, 16'h0001);
        chk({3'h0, fill}, 16'h0000);
        @(posedge clk);
        hold <= 1'b0;
        cyc(3);
        chk({8'h0, taken}, 16'h0009);
        chk({15'h0, stall}, 16'h0000);
        chk({2'h0, last}, 16'h0002);
        $display("test stall done");
    endtask
    task close_out;
        $display("checks %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        hold <= 1'b0;
        cyc(3);
        t_manual;
        t_auto;
        t_lost;
        t_held;
        t_freeze;
        t_stall;
        close_out;
    end
    // the tests need about a hundred and ten cycles
    initial begin
        #20000;
        miscompares++;
        close_out;
    end
endmodule
